// file: design/fpl_top.sv
// Fast-lock control core: slip reduction cells, bandwidth switching and output pin.
`timescale 1ns/10ps
module fpl_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic reference_input,
   input wire logic vco_feedback,
   input wire logic freq_write,
   input wire logic [fpl_pkg::INT_W-1:0] int_word,
   input wire logic [fpl_pkg::PARTIAL_STEP_COUNT_W-1:0] partial_step_count,
   input wire logic [fpl_pkg::PARTIAL_STEP_COUNT_W-1:0] step_denominator,
   input wire logic doubler_en,
   input wire logic halve_en,
   input wire logic [fpl_pkg::REF_CNT_W-1:0] ref_count,
   input wire logic slip_reduction_en,
   input wire logic [1:0] clk_div_mode,
   input wire logic [fpl_pkg::TIMER_W-1:0] clk_div_value,
   input wire logic [3:0] pin_select,
   input wire logic [fpl_pkg::CP_W-1:0] cp_current_set,
   output logic [fpl_pkg::CP_W-1:0] cp_current,
   output logic [fpl_pkg::CELL_W-1:0] extra_cells,
   output logic extra_cells_source,
   output logic wideband,
   output logic fastlock_switch,
   output logic selectable_output_pin_o,
   output logic selectable_output_pin_oe,
   output logic resync_pulse,
   output logic pfd_tick,
   output logic fb_tick
);
   fpl_tick_if ticks ();

   // ********************************************************************
   // Divider paths
   // ********************************************************************
   fpl_ref_path u_ref (
      .clk(clk),
      .rst(rst),
      .reference_input(reference_input),
      .doubler_en(doubler_en),
      .halve_en(halve_en),
      .ref_count(ref_count),
      .ticks(ticks.ref_src)
   );

   fpl_partial_step_count_div u_fb (
      .clk(clk),
      .rst(rst),
      .vco_feedback(vco_feedback),
      .freq_write(freq_write),
      .int_word(int_word),
      .partial_step_count(partial_step_count),
      .step_denominator(step_denominator),
      .ticks(ticks.fb_src)
   );

   // ********************************************************************
   // Cycle slip reduction
   // ********************************************************************
   // The lead counter is a coarse digital phase detector; it only needs to
   // tell a looming slip from normal jitter, so three bits are enough.
   fpl_pkg::fpl_slip_e slip_reg, slip_next;
   logic signed [fpl_pkg::LEAD_W-1:0] lead_reg, lead_next;
   logic [fpl_pkg::CELL_W-1:0] cells_reg, cells_next;
   logic source_reg, source_next;
   logic signed [fpl_pkg::LEAD_W-1:0] lead_upd;
   logic same_slip;
   logic passed;

   always_comb begin
      lead_upd = lead_reg;
      if (ticks.pfd_tick && !ticks.fb_tick && lead_reg != fpl_pkg::LEAD_SAT) begin
         lead_upd = lead_reg + 3'sh1;
      end else if (ticks.fb_tick && !ticks.pfd_tick && lead_reg != -fpl_pkg::LEAD_SAT) begin
         lead_upd = lead_reg - 3'sh1;
      end
      lead_next = lead_upd;
      slip_next = slip_reg;
      cells_next = cells_reg;
      source_next = source_reg;
      same_slip = source_reg ? (lead_upd >= fpl_pkg::SLIP_LEAD) : (lead_upd <= -fpl_pkg::SLIP_LEAD);
      passed = source_reg ? (lead_upd < 3'sh0) : (lead_upd > 3'sh0);
      if (!slip_reduction_en) begin
         slip_next = fpl_pkg::FPL_SLIP_IDLE;
         cells_next = fpl_pkg::CELL_RST;
      end else begin
         unique case (slip_reg)
            fpl_pkg::FPL_SLIP_IDLE: begin
               if (lead_upd >= fpl_pkg::SLIP_LEAD || lead_upd <= -fpl_pkg::SLIP_LEAD) begin
                  cells_next = 3'h1;
                  source_next = lead_upd > 3'sh0;
                  lead_next = 3'sh0;
                  slip_next = fpl_pkg::FPL_SLIP_RAMP_UP;
               end
            end
            fpl_pkg::FPL_SLIP_RAMP_UP: begin
               if (passed) begin
                  slip_next = fpl_pkg::FPL_SLIP_RAMP_DOWN;
               end else if (same_slip) begin
                  if (cells_reg != fpl_pkg::CELL_MAX) begin
                     cells_next = cells_reg + 3'h1;
                  end
                  lead_next = 3'sh0;
               end
            end
            fpl_pkg::FPL_SLIP_RAMP_DOWN: begin
               if (ticks.pfd_tick) begin
                  if (cells_reg > 3'h1) begin
                     cells_next = cells_reg - 3'h1;
                  end else begin
                     cells_next = fpl_pkg::CELL_RST;
                     lead_next = 3'sh0;
                     slip_next = fpl_pkg::FPL_SLIP_IDLE;
                  end
               end
            end
         endcase
      end
      if (freq_write) begin
         lead_next = 3'sh0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         slip_reg <= fpl_pkg::FPL_SLIP_IDLE;
         lead_reg <= 3'sh0;
         cells_reg <= fpl_pkg::CELL_RST;
         source_reg <= 1'b0;
      end else begin
         slip_reg <= slip_next;
         lead_reg <= lead_next;
         cells_reg <= cells_next;
         source_reg <= source_next;
      end
   end

   // ********************************************************************
   // Bandwidth switching and resync timer
   // ********************************************************************
   logic wb_reg, wb_next;
   logic [fpl_pkg::TIMER_W-1:0] timer_reg, timer_next;
   logic [fpl_pkg::TIMER_W-1:0] rs_div_reg, rs_div_next;
   logic [fpl_pkg::PARTIAL_STEP_COUNT_W-1:0] rs_mod_reg, rs_mod_next;
   logic [1:0] rs_seen_reg, rs_seen_next;
   logic rs_pulse_reg, rs_pulse_next;
   logic rs_sync;

   always_comb begin
      wb_next = wb_reg;
      timer_next = timer_reg;
      // A write in the same cycle as the last tick wins, so a reload is never lost.
      // start timer, boost and switch
      if (freq_write && clk_div_mode == fpl_pkg::DIV_MODE_FASTLOCK && clk_div_value != 12'h000) begin
         wb_next = 1'b1;
         timer_next = clk_div_value;
      end else if (wb_reg && ticks.pfd_tick) begin
         if (timer_reg == 12'h001) begin
            wb_next = 1'b0;
            timer_next = fpl_pkg::TIMER_RST;
         end else begin
            timer_next = timer_reg - 12'h001;
         end
      end
   end

   // Sync ticks come every divider value times modulus detector cycles; the
   // second one after a frequency write is the one that realigns phase.
   always_comb begin
      rs_div_next = rs_div_reg;
      rs_mod_next = rs_mod_reg;
      rs_seen_next = rs_seen_reg;
      rs_pulse_next = 1'b0;
      rs_sync = 1'b0;
      if (clk_div_mode != fpl_pkg::DIV_MODE_RESYNC || freq_write) begin
         rs_div_next = fpl_pkg::TIMER_RST;
         rs_mod_next = fpl_pkg::ACC_RST;
         rs_seen_next = {1'b0, clk_div_mode == fpl_pkg::DIV_MODE_RESYNC};
      end else if (ticks.pfd_tick) begin
         if (rs_mod_reg + 12'h001 >= step_denominator) begin
            rs_mod_next = fpl_pkg::ACC_RST;
            if (rs_div_reg + 12'h001 >= clk_div_value) begin
               rs_div_next = fpl_pkg::TIMER_RST;
               rs_sync = 1'b1;
            end else begin
               rs_div_next = rs_div_reg + 12'h001;
            end
         end else begin
            rs_mod_next = rs_mod_reg + 12'h001;
         end
      end
      if (rs_sync && rs_seen_reg != 2'h0) begin
         rs_seen_next = rs_seen_reg + 2'h1;
         rs_pulse_next = rs_seen_reg == 2'h2;
         if (rs_seen_reg == 2'h2) begin
            rs_seen_next = 2'h0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wb_reg <= 1'b0;
         timer_reg <= fpl_pkg::TIMER_RST;
      end else begin
         wb_reg <= wb_next;
         timer_reg <= timer_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rs_div_reg <= fpl_pkg::TIMER_RST;
         rs_mod_reg <= fpl_pkg::ACC_RST;
         rs_seen_reg <= 2'h0;
         rs_pulse_reg <= 1'b0;
      end else begin
         rs_div_reg <= rs_div_next;
         rs_mod_reg <= rs_mod_next;
         rs_seen_reg <= rs_seen_next;
         rs_pulse_reg <= rs_pulse_next;
      end
   end

   // ********************************************************************
   // Output registers
   // ********************************************************************
   logic [fpl_pkg::CP_W-1:0] cp_reg, cp_next;
   logic sw_reg, sw_next;
   logic pfd_reg, pfd_next;
   logic fb_reg, fb_next;

   always_comb begin
      cp_next = wb_next ? fpl_pkg::CP_CURRENT_MAX : cp_current_set;
      sw_next = wb_next && pin_select == fpl_pkg::PIN_SEL_FASTLOCK;
      // Tick copies pass a flip-flop so every output except the constant selectable_output_pin_o leaves a register.
      pfd_next = ticks.pfd_tick;
      fb_next = ticks.fb_tick;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cp_reg <= fpl_pkg::CP_CURRENT_RST;
         sw_reg <= 1'b0;
         pfd_reg <= 1'b0;
         fb_reg <= 1'b0;
      end else begin
         cp_reg <= cp_next;
         sw_reg <= sw_next;
         pfd_reg <= pfd_next;
         fb_reg <= fb_next;
      end
   end

   // The closed switch pulls the pin to ground, so it drives low only.
   assign cp_current = cp_reg;
   assign extra_cells = cells_reg;
   assign extra_cells_source = source_reg;
   assign wideband = wb_reg;
   assign fastlock_switch = sw_reg;
   assign selectable_output_pin_o = 1'b0;
   assign selectable_output_pin_oe = sw_reg;
   assign resync_pulse = rs_pulse_reg;
   assign pfd_tick = pfd_reg;
   assign fb_tick = fb_reg;
endmodule

// file: design/fpl_pkg.sv
// Shared constants and types for the fractional synthesizer fast-lock control.
package fpl_pkg;
   // ********************************************************************
   // Widths
   // ********************************************************************
   localparam int INT_W = 16;
   localparam int PARTIAL_STEP_COUNT_W = 12;
   localparam int REF_CNT_W = 5;
   localparam int TIMER_W = 12;
   localparam int CP_W = 4;
   localparam int CELL_W = 3;
   localparam int LEAD_W = 3;

   // ********************************************************************
   // Codes
   // ********************************************************************
   localparam logic [1:0] DIV_MODE_OFF = 2'h0;
   localparam logic [1:0] DIV_MODE_FASTLOCK = 2'h1;
   localparam logic [1:0] DIV_MODE_RESYNC = 2'h2;
   localparam logic [3:0] PIN_SEL_FASTLOCK = 4'hc;
   localparam logic [CP_W-1:0] CP_CURRENT_MAX = 4'hf;
   localparam logic [CELL_W-1:0] CELL_MAX = 3'h7;
   localparam logic signed [LEAD_W-1:0] SLIP_LEAD = 3'sh2;
   localparam logic signed [LEAD_W-1:0] LEAD_SAT = 3'sh3;

   // ********************************************************************
   // Reset values
   // ********************************************************************
   localparam logic [CP_W-1:0] CP_CURRENT_RST = 4'h0;
   localparam logic [TIMER_W-1:0] TIMER_RST = 12'h000;
   localparam logic [CELL_W-1:0] CELL_RST = 3'h0;
   localparam logic [REF_CNT_W-1:0] REF_CNT_RST = 5'h00;
   localparam logic [INT_W-1:0] FB_CNT_RST = 16'h0000;
   localparam logic [PARTIAL_STEP_COUNT_W-1:0] ACC_RST = 12'h000;

   typedef enum logic [1:0] {
      FPL_SLIP_IDLE,
      FPL_SLIP_RAMP_UP,
      FPL_SLIP_RAMP_DOWN
   } fpl_slip_e;
endpackage

// file: design/fpl_tick_if.sv
// Tick carrier between the divider paths and the control core.
`timescale 1ns/10ps
interface fpl_tick_if;
   logic pfd_tick;
   logic fb_tick;
   modport ref_src (output pfd_tick);
   modport fb_src (output fb_tick);
   modport core (input pfd_tick, input fb_tick);
endinterface

// file: design/fpl_ref_path.sv
// Reference path: doubler, 5-bit reference counter and divide-by-two.
`timescale 1ns/10ps
module fpl_ref_path (
   input wire logic clk,
   input wire logic rst,
   input wire logic reference_input,
   input wire logic doubler_en,
   input wire logic halve_en,
   input wire logic [fpl_pkg::REF_CNT_W-1:0] ref_count,
   fpl_tick_if.ref_src ticks
);
   logic sync1_reg, sync1_next;
   logic sync2_reg, sync2_next;
   logic last_reg, last_next;
   logic [fpl_pkg::REF_CNT_W-1:0] cnt_reg, cnt_next;
   logic half_reg, half_next;
   logic tick_reg, tick_next;
   logic edge_hit;
   logic div_hit;

   // ********************************************************************
   // Division
   // ********************************************************************
   always_comb begin
      sync1_next = reference_input;
      sync2_next = sync1_reg;
      last_next = sync2_reg;
      edge_hit = (sync2_reg & ~last_reg) | (doubler_en & ~sync2_reg & last_reg);
      cnt_next = cnt_reg;
      div_hit = 1'b0;
      if (edge_hit) begin
         if (cnt_reg + 5'h01 >= ref_count) begin
            cnt_next = fpl_pkg::REF_CNT_RST;
            div_hit = 1'b1;
         end else begin
            cnt_next = cnt_reg + 5'h01;
         end
      end
      half_next = half_reg ^ (div_hit & halve_en);
      tick_next = div_hit & (~halve_en | half_reg);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         last_reg <= 1'b0;
         cnt_reg <= fpl_pkg::REF_CNT_RST;
         half_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         last_reg <= last_next;
         cnt_reg <= cnt_next;
         half_reg <= half_next;
         tick_reg <= tick_next;
      end
   end

   assign ticks.pfd_tick = tick_reg;
endmodule

// file: design/fpl_partial_step_count_div.sv
// Fractional feedback divider: integer count plus accumulator carry.
`timescale 1ns/10ps
module fpl_partial_step_count_div (
   input wire logic clk,
   input wire logic rst,
   input wire logic vco_feedback,
   input wire logic freq_write,
   input wire logic [fpl_pkg::INT_W-1:0] int_word,
   input wire logic [fpl_pkg::PARTIAL_STEP_COUNT_W-1:0] partial_step_count,
   input wire logic [fpl_pkg::PARTIAL_STEP_COUNT_W-1:0] step_denominator,
   fpl_tick_if.fb_src ticks
);
   logic sync1_reg, sync1_next;
   logic sync2_reg, sync2_next;
   logic last_reg, last_next;
   logic [fpl_pkg::INT_W-1:0] cnt_reg, cnt_next;
   logic [fpl_pkg::PARTIAL_STEP_COUNT_W-1:0] acc_reg, acc_next;
   logic extra_reg, extra_next;
   logic tick_reg, tick_next;
   logic [fpl_pkg::PARTIAL_STEP_COUNT_W:0] acc_sum;
   logic [fpl_pkg::INT_W:0] target;

   // ********************************************************************
   // Division by int plus fraction
   // ********************************************************************
   always_comb begin
      sync1_next = vco_feedback;
      sync2_next = sync1_reg;
      last_next = sync2_reg;
      cnt_next = cnt_reg;
      acc_next = acc_reg;
      extra_next = extra_reg;
      tick_next = 1'b0;
      acc_sum = {1'b0, acc_reg} + {1'b0, partial_step_count};
      target = {1'b0, int_word} + {16'h0000, extra_reg};
      if (freq_write) begin
         cnt_next = fpl_pkg::FB_CNT_RST;
         acc_next = fpl_pkg::ACC_RST;
         extra_next = 1'b0;
      end else if (sync2_reg & ~last_reg) begin
         // ratio int plus fraction over modulus
         if ({1'b0, cnt_reg} + 17'h00001 >= target) begin
            cnt_next = fpl_pkg::FB_CNT_RST;
            tick_next = 1'b1;
            if (acc_sum >= {1'b0, step_denominator}) begin
               acc_next = acc_sum[fpl_pkg::PARTIAL_STEP_COUNT_W-1:0] - step_denominator;
               extra_next = 1'b1;
            end else begin
               acc_next = acc_sum[fpl_pkg::PARTIAL_STEP_COUNT_W-1:0];
               extra_next = 1'b0;
            end
         end else begin
            cnt_next = cnt_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         last_reg <= 1'b0;
         cnt_reg <= fpl_pkg::FB_CNT_RST;
         acc_reg <= fpl_pkg::ACC_RST;
         extra_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         last_reg <= last_next;
         cnt_reg <= cnt_next;
         acc_reg <= acc_next;
         extra_reg <= extra_next;
         tick_reg <= tick_next;
      end
   end

   assign ticks.fb_tick = tick_reg;
endmodule

// file: sim/fpl_vco_model.sv
// Behavioural oscillator standing in for the VCO at the far side of the loop.
`timescale 1ns/10ps
module fpl_vco_model (
   input wire logic clk,
   input wire logic [7:0] half_cycles,
   output logic vco_feedback
);
   // The rate stands in for the tuning voltage, so the bench can make it fast or slow on command.
   logic [7:0] count_reg = 8'h00;
   logic vco_reg = 1'b0;
   assign vco_feedback = vco_reg;
   always @(posedge clk) begin
      if (count_reg + 8'h01 >= half_cycles) begin
         count_reg <= 8'h00;
         vco_reg <= ~vco_reg;
      end else begin
         count_reg <= count_reg + 8'h01;
      end
   end
endmodule

// file: sim/fpl_top_sva.sv
// Port checker for the fast-lock control block.
`timescale 1ns/10ps
module fpl_top_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic freq_write,
   input wire logic slip_reduction_en,
   input wire logic [1:0] clk_div_mode,
   input wire logic [fpl_pkg::TIMER_W-1:0] clk_div_value,
   input wire logic [3:0] pin_select,
   input wire logic [fpl_pkg::CP_W-1:0] cp_current_set,
   input wire logic [fpl_pkg::CP_W-1:0] cp_current,
   input wire logic [fpl_pkg::CELL_W-1:0] extra_cells,
   input wire logic wideband,
   input wire logic fastlock_switch,
   input wire logic selectable_output_pin_o,
   input wire logic selectable_output_pin_oe,
   input wire logic resync_pulse
);
   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wideband_start_a:
   assert property (freq_write && clk_div_mode == 2'h1 && clk_div_value != 12'h000
      |=> wideband && cp_current == fpl_pkg::CP_CURRENT_MAX) else $error("wideband not entered");
   refused_write_a:
   assert property (freq_write && !wideband && (clk_div_mode != 2'h1 || clk_div_value == 12'h000)
      |=> !wideband) else $error("wideband from refused write");
   rise_cause_a:
   assert property ($rose(wideband) |-> $past(freq_write) && $past(clk_div_mode) == 2'h1)
      else $error("wideband rose without write");
   boost_level_a:
   assert property (wideband |-> cp_current == fpl_pkg::CP_CURRENT_MAX) else $error("boost missing");
   narrow_current_a:
   assert property (!wideband && !$past(rst) |-> cp_current == $past(cp_current_set))
      else $error("pump current not at setting");
   pin_show_a:
   assert property (wideband && $past(pin_select) == 4'hc |-> fastlock_switch) else $error("switch missing");
   pin_drive_a:
   assert property (selectable_output_pin_oe == fastlock_switch && selectable_output_pin_o == 1'b0
      && (!fastlock_switch || wideband)) else $error("pin drive wrong");
   cell_step_a:
   assert property ($past(slip_reduction_en) && !$past(rst) && extra_cells != $past(extra_cells)
      |-> {1'b0, extra_cells} == {1'b0, $past(extra_cells)} + 4'h1
      || {1'b0, $past(extra_cells)} == {1'b0, extra_cells} + 4'h1) else $error("cell step not one");
   csr_off_a:
   assert property (!slip_reduction_en |=> extra_cells == 3'h0) else $error("cells while disabled");
   resync_mode_a:
   assert property (resync_pulse |-> $past(clk_div_mode) == 2'h2) else $error("resync outside mode");
   cover property ($rose(wideband));
   cover property (extra_cells == 3'h7);
   cover property (resync_pulse);
endmodule
bind fpl_top fpl_top_sva fpl_top_sva_i (.clk(clk), .rst(rst), .freq_write(freq_write),
   .slip_reduction_en(slip_reduction_en), .clk_div_mode(clk_div_mode), .clk_div_value(clk_div_value),
   .pin_select(pin_select), .cp_current_set(cp_current_set), .cp_current(cp_current),
   .extra_cells(extra_cells), .wideband(wideband), .fastlock_switch(fastlock_switch),
   .selectable_output_pin_o(selectable_output_pin_o), .selectable_output_pin_oe(selectable_output_pin_oe),
   .resync_pulse(resync_pulse));

// file: sim/tb_top.sv
// Self-checking bench for the fast-lock control block.
`timescale 1ns/10ps
module tb_top;
   // ********************************************************************
   // Stimulus and checks
   // ********************************************************************
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reference_input = 1'b0;
   logic vco_feedback;
   logic freq_write = 1'b0;
   logic [fpl_pkg::INT_W-1:0] int_word = 16'h0005;
   logic [fpl_pkg::PARTIAL_STEP_COUNT_W-1:0] partial_step_count = 12'h000;
   logic [fpl_pkg::PARTIAL_STEP_COUNT_W-1:0] step_denominator = 12'h001;
   logic doubler_en = 1'b0;
   logic halve_en = 1'b0;
   logic [fpl_pkg::REF_CNT_W-1:0] ref_count = 5'h01;
   logic slip_reduction_en = 1'b0;
   logic [1:0] clk_div_mode = 2'h0;
   logic [fpl_pkg::TIMER_W-1:0] clk_div_value = 12'h005;
   logic [3:0] pin_select = 4'hc;
   logic [fpl_pkg::CP_W-1:0] cp_current_set = 4'h3;
   logic [7:0] vco_half = 8'h02;
   logic [3:0] ref_phase = 4'h0;
   logic [fpl_pkg::CP_W-1:0] cp_current;
   logic [fpl_pkg::CELL_W-1:0] extra_cells;
   logic extra_cells_source, wideband, fastlock_switch, selectable_output_pin_o, selectable_output_pin_oe;
   logic resync_pulse, pfd_tick, fb_tick, seen, busy;
   logic [6:0] rcfg [5] = '{7'h01, 7'h41, 7'h23, 7'h7f, 7'h00};
   int rgap [5] = '{20, 10, 120, 620, 20};
   logic [39:0] fcfg [4] = '{40'h0005000001, 40'h0003001004, 40'h0002003004, 40'h0004002003};
   logic [13:0] mcfg [3] = '{14'h0005, 14'h2005, 14'h1000};
   int mismatches = 0;
   int cmp_count = 0;
   int gap;
   int dur;

   fpl_top fpl_top_i (.clk(clk), .rst(rst), .reference_input(reference_input), .vco_feedback(vco_feedback),
      .freq_write(freq_write), .int_word(int_word), .partial_step_count(partial_step_count),
      .step_denominator(step_denominator), .doubler_en(doubler_en), .halve_en(halve_en), .ref_count(ref_count),
      .slip_reduction_en(slip_reduction_en), .clk_div_mode(clk_div_mode), .clk_div_value(clk_div_value),
      .pin_select(pin_select), .cp_current_set(cp_current_set), .cp_current(cp_current),
      .extra_cells(extra_cells), .extra_cells_source(extra_cells_source), .wideband(wideband),
      .fastlock_switch(fastlock_switch), .selectable_output_pin_o(selectable_output_pin_o),
      .selectable_output_pin_oe(selectable_output_pin_oe), .resync_pulse(resync_pulse),
      .pfd_tick(pfd_tick), .fb_tick(fb_tick));
   fpl_vco_model fpl_vco_model_i (.clk(clk), .half_cycles(vco_half), .vco_feedback(vco_feedback));

   always #5 clk = ~clk;

   // even duty at 5 MHz, well under the rate limit.
   always @(posedge clk) begin
      ref_phase <= (ref_phase == 4'h9) ? 4'h0 : ref_phase + 4'h1;
      if (ref_phase == 4'h9) begin
         reference_input <= ~reference_input;
      end
   end

   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic write_freq;
      @(posedge clk);
      freq_write <= 1'b1;
      @(posedge clk);
      freq_write <= 1'b0;
      #1;
   endtask

   // Skipping two ticks lets the synchronisers and old counts drain first.
   task automatic span(input logic use_fb, input int n, output int cycles);
      int ticks;
      ticks = 0;
      cycles = 0;
      while (ticks < n + 3) begin
         cyc(1);
         if ((use_fb ? fb_tick : pfd_tick) === 1'b1) ticks++;
         if (ticks >= 3) cycles++;
      end
      cycles = cycles - 1;
   endtask

   task automatic hold_time(output int cycles);
      cycles = 0;
      while (wideband === 1'b1 && cycles < 10000) begin
         cyc(1);
         cycles++;
      end
   endtask

   task automatic wait_cells(input logic [2:0] want, input logic dir, input string msg);
      int n;
      n = 0;
      while (!(extra_cells === want && (want == 3'h0 || extra_cells_source === dir)) && n < 3000) begin
         cyc(1);
         n++;
      end
      chk(extra_cells === want && (want == 3'h0 || extra_cells_source === dir), msg);
   endtask

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (50000) @(posedge clk);
      mismatches++;
      $display("unexpected at %0t: watchdog expired", $time);
      close_out;
   end

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         {doubler_en, halve_en, ref_count} <= rcfg[i];
         span(1'b0, 1, gap);
         chk(gap == rgap[i], "pfd tick spacing");
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {int_word, partial_step_count, step_denominator} <= fcfg[i];
         write_freq;
         span(1'b1, int'(fcfg[i][11:0]), gap);
         chk(gap == int'(fcfg[i][39:24] * fcfg[i][11:0] + fcfg[i][23:12]) * 4, "feedback ratio");
      end
      @(posedge clk);
      {int_word, partial_step_count, step_denominator} <= fcfg[0];
      // five ticks are short of a real settle; fine for the digital side.
      clk_div_mode <= 2'h1;
      write_freq;
      cyc(1);
      chk(wideband === 1'b1 && cp_current === 4'hf && fastlock_switch === 1'b1, "wideband entry");
      chk(selectable_output_pin_oe === 1'b1 && selectable_output_pin_o === 1'b0, "pin pulled low");
      hold_time(dur);
      chk(dur > 78 && dur < 122, "wideband span");
      chk(cp_current === cp_current_set && selectable_output_pin_oe === 1'b0, "narrowband return");
      write_freq;
      cyc(60);
      write_freq;
      cyc(1);
      hold_time(dur);
      chk(dur > 78 && dur < 122, "reloaded span");
      @(posedge clk);
      pin_select <= 4'h0;
      write_freq;
      cyc(1);
      chk(wideband === 1'b1 && selectable_output_pin_oe === 1'b0, "switch off pin");
      hold_time(dur);
      @(posedge clk);
      pin_select <= 4'hc;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         {clk_div_mode, clk_div_value} <= mcfg[i];
         write_freq;
         seen = 1'b0;
         busy = 1'b0;
         repeat (300) begin
            cyc(1);
            if (resync_pulse === 1'b1) seen = 1'b1;
            if (wideband !== 1'b0) busy = 1'b1;
         end
         chk(busy === 1'b0 && seen === (mcfg[i][13:12] == 2'h2), "mode select");
      end
      @(posedge clk);
      clk_div_mode <= 2'h0;
      // polarity follows the sign of the lead counter when a slip starts, so sink first, then source.
      slip_reduction_en <= 1'b1;
      int_word <= 16'h0001;
      vco_half <= 8'h01;
      wait_cells(3'h7, 1'b0, "sink ramp to seven");
      cyc(200);
      chk(extra_cells === 3'h7, "cells saturate");
      @(posedge clk);
      int_word <= 16'h0064;
      vco_half <= 8'h02;
      wait_cells(3'h0, 1'b0, "ramp down to none");
      wait_cells(3'h7, 1'b1, "source ramp to seven");
      @(posedge clk);
      slip_reduction_en <= 1'b0;
      cyc(2);
      chk(extra_cells === 3'h0, "cells cleared when off");
      close_out;
   end
endmodule
